/* deep_sync_fifo.sv */
// Deep synchronous FIFO with programmable almost-empty and almost-full flags

// Behaviour
// R1: Running clocks during reset do no harm.
// R2: After reset, outputs low or released per enable.
// R3: Pin high at reset: second write enable.
// R4: Pin low at reset: offset load enable.
// R5: Full flag follows reads within skew bound.
// R6: Empty flag follows writes within skew bound.
// R7: First word readable cycle after empty clears.
// R8: Extra first-read latency only at empty.
// R9: Almost-empty follows writes within skew bound.
// R10: Almost-full follows reads within skew bound.
// R11: Read at almost-empty edge leaves n-1.
// R12: Write at almost-full edge leaves full-(m-1).
// R13: Both offsets default to seven words.
// R14: Writes ignored while full; flag on clock.
// R15: Reads ignored while empty; flag on clock.
// R16: Flag updates stay glitch-free and conservative.
// R17: Reader waits for empty release; writer stops full.
module deep_sync_fifo (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [deep_fifo_pkg::DATA_W-1:0] data_in,
    input wire logic primary_write_enable_n,
    input wire logic second_write_enable_or_load,
    input wire logic primary_read_enable_n,
    input wire logic secondary_read_enable,
    input wire logic output_enable_n,
    output logic [deep_fifo_pkg::DATA_W-1:0] data_out,
    output logic data_out_oe_n,
    output logic full_flag_n,
    output logic empty_flag_n,
    output logic almost_empty_flag_n,
    output logic almost_full_flag_n
);
    import deep_fifo_pkg::*;

    // ************************************************
    // Main storage
    // ************************************************
    logic [DATA_W-1:0] store_q [FIFO_DEPTH];
    logic [DATA_W-1:0] store_rd_q;

    // ************************************************
    // State
    // ************************************************
    pin_mode_t mode_q, mode_d;
    logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d;
    logic [PTR_W-1:0] rd_ptr_q, rd_ptr_d;
    logic [PTR_W-1:0] count_q, count_d;
    logic pend_q, pend_d;
    logic full_n_q, full_n_d;
    logic empty_n_q, empty_n_d;
    logic ae_n_q, ae_n_d;
    logic af_n_q, af_n_d;
    logic [DATA_W-1:0] dout_q, dout_d;
    logic oe_n_q, oe_n_d;

    // ************************************************
    // Request decode
    // ************************************************
    logic wr_req, rd_req, wr_accept, rd_accept;
    logic load_wr, load_rd;
    logic [PTR_W-1:0] store_words;
    logic issue;
    logic [BUF_LVL_W:0] buf_room_used;
    logic [BUF_LVL_W-1:0] buf_level, buf_level_next;
    logic buf_in_ready, buf_out_valid;
    logic [DATA_W-1:0] buf_out_data;
    logic buf_push;

    // ************************************************
    // Offsets
    // ************************************************
    logic [OFF_W-1:0] empty_offset, full_offset;
    logic [DATA_W-1:0] offset_rd_data;

    offset_regs u_offsets (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .load_write(load_wr),
        .load_read(load_rd),
        .load_data(data_in),
        .empty_offset(empty_offset),
        .full_offset(full_offset),
        .read_data(offset_rd_data)
    );

    // ************************************************
    // Output staging buffer between storage and pins
    // ************************************************
    stream_buffer #(
        .WIDTH(DATA_W),
        .DEPTH(BUF_DEPTH),
        .LVL_W(BUF_LVL_W)
    ) u_stage (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_valid(pend_q),
        .in_ready(buf_in_ready),
        .in_data(store_rd_q),
        .out_valid(buf_out_valid),
        .out_ready(rd_accept),
        .out_data(buf_out_data),
        .level(buf_level)
    );

    // ************************************************
    // Pin mode capture
    // ************************************************
    // Sampled on the first edge after reset release; the clocks may
    // run freely while reset is held since nothing else moves then
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            MODE_INIT: begin
                if (second_write_enable_or_load) begin
                    mode_d = MODE_DUAL_ENABLE; // see R3
                end else begin
                    mode_d = MODE_LOAD; // see R4
                end
            end
            MODE_DUAL_ENABLE: mode_d = MODE_DUAL_ENABLE;
            MODE_LOAD: mode_d = MODE_LOAD;
            default: mode_d = MODE_INIT;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= MODE_INIT; // see R1
        end else begin
            mode_q <= mode_d;
        end
    end

    // ************************************************
    // Access qualification
    // ************************************************
    always_comb begin
        wr_req = 1'b0;
        rd_req = 1'b0;
        load_wr = 1'b0;
        load_rd = 1'b0;
        case (mode_q)
            MODE_DUAL_ENABLE: begin
                wr_req = !primary_write_enable_n &&
                         second_write_enable_or_load; // see R3
                rd_req = !primary_read_enable_n && secondary_read_enable;
            end
            MODE_LOAD: begin
                // Pin low selects the offset registers, high the FIFO
                wr_req = !primary_write_enable_n &&
                         second_write_enable_or_load;
                rd_req = !primary_read_enable_n && secondary_read_enable &&
                         second_write_enable_or_load;
                load_wr = !primary_write_enable_n &&
                          !second_write_enable_or_load; // see R4
                load_rd = !primary_read_enable_n && secondary_read_enable &&
                          !second_write_enable_or_load; // see R4
            end
            MODE_INIT: begin
                wr_req = 1'b0;
                rd_req = 1'b0;
            end
            default: begin
                wr_req = 1'b0;
                rd_req = 1'b0;
            end
        endcase
        wr_accept = wr_req && full_n_q; // see R14
        rd_accept = rd_req && empty_n_q; // see R15
    end

    // ************************************************
    // Storage pointers and refill of the staging buffer
    // ************************************************
    always_comb begin
        store_words = wr_ptr_q - rd_ptr_q;
        buf_room_used = {1'b0, buf_level} + (BUF_LVL_W + 1)'(pend_q);
        // Keep at most one read in flight and never overrun the buffer
        issue = (store_words != '0) &&
                (buf_room_used < (BUF_LVL_W + 1)'(BUF_DEPTH)) &&
                (!pend_q || buf_in_ready);
        buf_push = pend_q && buf_in_ready;
        wr_ptr_d = wr_accept ? wr_ptr_q + 1'b1 : wr_ptr_q;
        rd_ptr_d = issue ? rd_ptr_q + 1'b1 : rd_ptr_q;
        pend_d = issue || (pend_q && !buf_in_ready);
    end

    always_ff @(posedge core_clk) begin
        if (wr_accept) begin
            store_q[wr_ptr_q[ADDR_W-1:0]] <= data_in;
        end
        if (issue) begin
            store_rd_q <= store_q[rd_ptr_q[ADDR_W-1:0]];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            pend_q <= 1'b0;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            pend_q <= pend_d;
        end
    end

    // ************************************************
    // Word count and flags
    // ************************************************
    // Every flag is a flop, full and the almost flags fed from the next count
    // and empty from the next buffer level, so each changes once per edge and never glitches
    always_comb begin
        count_d = count_q + PTR_W'(wr_accept) - PTR_W'(rd_accept);
        buf_level_next = buf_level + BUF_LVL_W'(buf_push) -
                         BUF_LVL_W'(rd_accept);
        full_n_d = (count_d != FIFO_DEPTH); // see R5
        // Empty clears only once a word sits at the buffer head
        empty_n_d = (buf_level_next != '0); // see R6 R8 R16
        // Low while count is at or below n
        ae_n_d = (count_d > PTR_W'(empty_offset)); // see R9 R11
        // Low while count is at or above depth minus m
        af_n_d = (count_d < FIFO_DEPTH - PTR_W'(full_offset)); // see R10 R12
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
            full_n_q <= 1'b1;
            empty_n_q <= 1'b0;
            ae_n_q <= 1'b0;
            af_n_q <= 1'b1;
        end else begin
            count_q <= count_d;
            full_n_q <= full_n_d; // see R14
            empty_n_q <= empty_n_d; // see R15 R16
            ae_n_q <= ae_n_d;
            af_n_q <= af_n_d;
        end
    end

    // ************************************************
    // Output data and drive enable
    // ************************************************
    // A word read on an edge appears on the pins after that edge,
    // so the first word follows the cycle in which empty cleared
    always_comb begin
        dout_d = dout_q;
        if (rd_accept) begin
            dout_d = buf_out_data; // see R7
        end else if (load_rd) begin
            dout_d = offset_rd_data;
        end
        oe_n_d = output_enable_n; // see R2
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dout_q <= '0; // see R2
            oe_n_q <= 1'b1;
        end else begin
            dout_q <= dout_d;
            oe_n_q <= oe_n_d;
        end
    end

    assign data_out = dout_q;
    assign data_out_oe_n = oe_n_q;
    assign full_flag_n = full_n_q;
    assign empty_flag_n = empty_n_q;
    assign almost_empty_flag_n = ae_n_q;
    assign almost_full_flag_n = af_n_q;

endmodule

/* deep_fifo_pkg.sv */
// Constants shared by the deep synchronous FIFO and its helpers
package deep_fifo_pkg;

    // ************************************************
    // Data path geometry
    // ************************************************
    localparam int DATA_W = 9;
    localparam int ADDR_W = 16;
    localparam int PTR_W = 17;
    localparam logic [PTR_W-1:0] FIFO_DEPTH = 17'h10000;

    // ************************************************
    // Output staging buffer
    // ************************************************
    localparam int BUF_DEPTH = 8;
    localparam int BUF_LVL_W = 4;

    // ************************************************
    // Programmable offsets
    // ************************************************
    localparam int OFF_W = 16;
    localparam int BYTE_W = 8;
    localparam logic [OFF_W-1:0] OFFSET_RESET = 16'h0007;
    localparam logic [1:0] SEL_EMPTY_LO = 2'h0;
    localparam logic [1:0] SEL_EMPTY_HI = 2'h1;
    localparam logic [1:0] SEL_FULL_LO = 2'h2;
    localparam logic [1:0] SEL_FULL_HI = 2'h3;

    // ************************************************
    // Timing
    // ************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int BOUNDARY_FLAG_SKEW_NS = 5;
    localparam int PARTIAL_FLAG_SKEW_NS = 10;
    localparam int BOUNDARY_FLAG_SKEW_CYC =
        (BOUNDARY_FLAG_SKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PARTIAL_FLAG_SKEW_CYC =
        (PARTIAL_FLAG_SKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ************************************************
    // Pin mode chosen at reset
    // ************************************************
    typedef enum logic [1:0] {
        MODE_INIT = 2'b00,
        MODE_DUAL_ENABLE = 2'b01,
        MODE_LOAD = 2'b10
    } pin_mode_t;

endpackage

/* stream_buffer.sv */
// Small synchronous FIFO with valid/ready on both sides
module stream_buffer #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8,
    parameter int LVL_W = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [LVL_W-1:0] level
);
    localparam int IDX_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [IDX_W-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [LVL_W-1:0] lvl_q, lvl_d;
    logic push, pop;

    assign in_ready = (lvl_q != LVL_W'(DEPTH));
    assign out_valid = (lvl_q != '0);
    assign out_data = mem_q[rp_q];
    assign level = lvl_q;

    always_comb begin
        push = in_valid && in_ready;
        pop = out_ready && out_valid;
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
        lvl_d = lvl_q + LVL_W'(push) - LVL_W'(pop);
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            lvl_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            lvl_q <= lvl_d;
        end
    end
endmodule

/* offset_regs.sv */
// Programmable empty and full offset registers, loaded a byte at a time
module offset_regs (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic load_write,
    input wire logic load_read,
    input wire logic [deep_fifo_pkg::DATA_W-1:0] load_data,
    output logic [deep_fifo_pkg::OFF_W-1:0] empty_offset,
    output logic [deep_fifo_pkg::OFF_W-1:0] full_offset,
    output logic [deep_fifo_pkg::DATA_W-1:0] read_data
);
    import deep_fifo_pkg::*;

    logic [OFF_W-1:0] empty_q, empty_d, full_q, full_d;
    logic [1:0] sel_q, sel_d;

    // Replace one byte of an offset, keeping the other
    function automatic logic [OFF_W-1:0] put_byte(
        input logic [OFF_W-1:0] old, input logic hi,
        input logic [BYTE_W-1:0] b);
        put_byte = hi ? {b, old[BYTE_W-1:0]} : {old[OFF_W-1:BYTE_W], b};
    endfunction

    assign empty_offset = empty_q;
    assign full_offset = full_q;

    always_comb begin
        empty_d = empty_q;
        full_d = full_q;
        sel_d = sel_q;
        case (sel_q)
            SEL_EMPTY_LO: read_data = DATA_W'(empty_q[BYTE_W-1:0]);
            SEL_EMPTY_HI: read_data = DATA_W'(empty_q[OFF_W-1:BYTE_W]);
            SEL_FULL_LO: read_data = DATA_W'(full_q[BYTE_W-1:0]);
            default: read_data = DATA_W'(full_q[OFF_W-1:BYTE_W]);
        endcase
        if (load_write) begin
            if (!sel_q[1]) begin
                empty_d = put_byte(empty_q, sel_q[0], load_data[BYTE_W-1:0]);
            end else begin
                full_d = put_byte(full_q, sel_q[0], load_data[BYTE_W-1:0]);
            end
        end
        if (load_write || load_read) begin
            sel_d = sel_q + 2'h1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            empty_q <= OFFSET_RESET; // see R13
            full_q <= OFFSET_RESET; // see R13
            sel_q <= SEL_EMPTY_LO;
        end else begin
            empty_q <= empty_d;
            full_q <= full_d;
            sel_q <= sel_d;
        end
    end
endmodule

/* deep_sync_fifo_checker.sv */
// Port assertions for the deep synchronous FIFO
module deep_sync_fifo_checker (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic primary_write_enable_n,
    input wire logic second_write_enable_or_load,
    input wire logic primary_read_enable_n,
    input wire logic secondary_read_enable,
    input wire logic output_enable_n,
    input wire logic [deep_fifo_pkg::DATA_W-1:0] data_out,
    input wire logic data_out_oe_n,
    input wire logic full_flag_n,
    input wire logic empty_flag_n,
    input wire logic almost_empty_flag_n,
    input wire logic almost_full_flag_n
);
    import deep_fifo_pkg::*;
    logic [2:0] up_q;
    logic [2:0] up_d;
    logic wr_ok;
    logic rd_try;
    assign wr_ok = !primary_write_enable_n && second_write_enable_or_load
        && full_flag_n;
    assign rd_try = !primary_read_enable_n && secondary_read_enable
        && empty_flag_n;
    // Bit 0: out of reset; bits 2:1: pin high on the last two edges
    always_comb up_d = {up_q[1], second_write_enable_or_load, 1'b1};
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_q <= 3'h0;
        end else begin
            up_q <= up_d;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_wr_into_empty;
        up_q[0] && !empty_flag_n && wr_ok;
    endsequence
    sequence s_word_staged;
        ##[1:3] empty_flag_n;
    endsequence
    a_oe_follows_req: assert property (
        up_q[0] |-> data_out_oe_n == $past(output_enable_n))
        else $error("output enable out of step");
    a_read_refused: assert property (
        !empty_flag_n && second_write_enable_or_load |=> $stable(data_out))
        else $error("data changed while empty");
    a_empty_fill: assert property (
        s_wr_into_empty |-> s_word_staged)
        else $error("first word not staged in time");
    a_full_holds: assert property (
        !full_flag_n && !rd_try |=> !full_flag_n)
        else $error("full flag dropped without a read");
    a_full_clear_rd: assert property (
        $rose(full_flag_n) |-> $past(rd_try))
        else $error("full flag cleared without a read");
    a_ae_rise_wr: assert property (
        $rose(almost_empty_flag_n) && up_q[2:1] == 2'h3 |-> $past(wr_ok))
        else $error("almost empty cleared without a write");
    a_ae_fall_rd: assert property (
        $fell(almost_empty_flag_n) && up_q[2:1] == 2'h3 |-> $past(rd_try))
        else $error("almost empty set without a read");
    a_af_rise_rd: assert property (
        $rose(almost_full_flag_n) && up_q[2:1] == 2'h3 |-> $past(rd_try))
        else $error("almost full cleared without a read");
endmodule

bind deep_sync_fifo deep_sync_fifo_checker chk_u (
    .core_clk(core_clk), .rst_n(rst_n),
    .primary_write_enable_n(primary_write_enable_n),
    .second_write_enable_or_load(second_write_enable_or_load),
    .primary_read_enable_n(primary_read_enable_n),
    .secondary_read_enable(secondary_read_enable),
    .output_enable_n(output_enable_n), .data_out(data_out),
    .data_out_oe_n(data_out_oe_n), .full_flag_n(full_flag_n),
    .empty_flag_n(empty_flag_n),
    .almost_empty_flag_n(almost_empty_flag_n),
    .almost_full_flag_n(almost_full_flag_n)
);

/* fifo_peer.sv */
// Writer and reader model facing the deep FIFO
module fifo_peer (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wr_go,
    input wire logic rd_go,
    input wire logic rude,
    input wire logic ld_en,
    input wire logic [7:0] ld_byte,
    input wire logic full_flag_n,
    input wire logic empty_flag_n,
    output logic [deep_fifo_pkg::DATA_W-1:0] data_in,
    output logic primary_write_enable_n,
    output logic primary_read_enable_n,
    output logic [16:0] wr_cnt
);
    import deep_fifo_pkg::*;
    logic push;
    // Rude mode pushes past the flags on purpose
    assign push = wr_go && (full_flag_n || rude);
    assign primary_write_enable_n = !(push || ld_en);
    assign primary_read_enable_n = !(rd_go && (empty_flag_n || rude));
    always_comb begin
        if (ld_en) begin
            data_in = {1'b0, ld_byte};
        end else if (push) begin
            data_in = wr_cnt[8:0];
        end else begin
            data_in = ~wr_cnt[8:0];
        end
    end
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_cnt <= 17'h0;
        end else if (push && full_flag_n) begin
            wr_cnt <= wr_cnt + 17'h1;
        end
    end
endmodule

/* deep_sync_fifo_tb.sv */
// Self-checking bench for the deep synchronous FIFO
module deep_sync_fifo_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import deep_fifo_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr_go = 1'b0;
    logic rd_go = 1'b0;
    logic rude = 1'b0;
    logic ld_en = 1'b0;
    logic [7:0] ld_byte = 8'h00;
    logic second_write_enable_or_load = 1'b1;
    logic secondary_read_enable = 1'b1;
    logic output_enable_n = 1'b0;
    logic [DATA_W-1:0] data_in;
    logic [DATA_W-1:0] data_out;
    logic primary_write_enable_n, primary_read_enable_n, data_out_oe_n;
    logic full_flag_n, empty_flag_n, almost_empty_flag_n;
    logic almost_full_flag_n;
    logic [16:0] wr_cnt;
    logic [3:0] flags;
    int err_count = 0;
    int samples_checked = 0;
    assign flags = {full_flag_n, empty_flag_n, almost_empty_flag_n,
        almost_full_flag_n};
    always #5 core_clk = ~core_clk;

    deep_sync_fifo dut_u (.core_clk(core_clk), .rst_n(rst_n),
        .data_in(data_in), .primary_write_enable_n(primary_write_enable_n),
        .second_write_enable_or_load(second_write_enable_or_load),
        .primary_read_enable_n(primary_read_enable_n),
        .secondary_read_enable(secondary_read_enable),
        .output_enable_n(output_enable_n), .data_out(data_out),
        .data_out_oe_n(data_out_oe_n), .full_flag_n(full_flag_n),
        .empty_flag_n(empty_flag_n),
        .almost_empty_flag_n(almost_empty_flag_n),
        .almost_full_flag_n(almost_full_flag_n));
    fifo_peer peer_u (.core_clk(core_clk), .rst_n(rst_n), .wr_go(wr_go),
        .rd_go(rd_go), .rude(rude), .ld_en(ld_en), .ld_byte(ld_byte),
        .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
        .data_in(data_in), .primary_write_enable_n(primary_write_enable_n),
        .primary_read_enable_n(primary_read_enable_n), .wr_cnt(wr_cnt));

    task automatic check(input string what, input logic [16:0] seen,
        input logic [16:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic do_reset(input logic mode);
        @(posedge core_clk);
        rst_n <= 1'b0;
        second_write_enable_or_load <= mode;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
    endtask

    task automatic write_n(input int n);
        @(posedge core_clk);
        wr_go <= 1'b1;
        repeat (n) @(posedge core_clk);
        wr_go <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic read_one(input logic [8:0] exp);
        int n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (empty_flag_n !== 1'b1 && n < 50);
        check("wait_bound", n >= 50, 17'h0);
        if (n >= 50) results();
        rd_go <= 1'b1;
        @(posedge core_clk);
        rd_go <= 1'b0;
        @(posedge core_clk);
        check("data_out", data_out, exp);
    endtask

    task automatic t_reset_state();
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge core_clk);
        check("flags", flags, 4'h9);
        check("data_out", data_out, 9'h000);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        check("data_out_oe_n", data_out_oe_n, 1'h0);
        output_enable_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        check("data_out_oe_n", data_out_oe_n, 1'h1);
        output_enable_n <= 1'b0;
        $display("test reset_state done");
    endtask

    task automatic t_first_words();
        int n = 0;
        @(posedge core_clk);
        rude <= 1'b1;
        rd_go <= 1'b1;
        repeat (3) @(posedge core_clk);
        rude <= 1'b0;
        rd_go <= 1'b0;
        check("data_out", data_out, 9'h000);
        wr_go <= 1'b1;
        @(posedge core_clk);
        wr_go <= 1'b0;
        do begin
            @(posedge core_clk);
            n++;
        end while (empty_flag_n !== 1'b1 && n < 9);
        check("first_read_latency", 17'(n), 17'h3);
        if (n >= 9) results();
        write_n(6);
        check("almost_empty_flag_n", almost_empty_flag_n, 1'h0);
        write_n(1);
        check("almost_empty_flag_n", almost_empty_flag_n, 1'h1);
        read_one(9'h000);
        check("almost_empty_flag_n", almost_empty_flag_n, 1'h0);
        for (int i = 1; i < 8; i++) read_one(i[8:0]);
        check("empty_flag_n", empty_flag_n, 1'h0);
        $display("test first_words done");
    endtask

    task automatic t_pin_gate();
        @(posedge core_clk);
        second_write_enable_or_load <= 1'b0;
        write_n(3);
        repeat (4) @(posedge core_clk);
        check("empty_flag_n", empty_flag_n, 1'h0);
        second_write_enable_or_load <= 1'b1;
        $display("test pin_gate done");
    endtask

    task automatic t_load_mode();
        logic [7:0] bytes [4] = '{8'h02, 8'h00, 8'h07, 8'h00};
        do_reset(1'b0);
        @(posedge core_clk);
        ld_en <= 1'b1;
        foreach (bytes[i]) begin
            ld_byte <= bytes[i];
            @(posedge core_clk);
        end
        ld_en <= 1'b0;
        rude <= 1'b1;
        rd_go <= 1'b1;
        @(posedge core_clk);
        rude <= 1'b0;
        rd_go <= 1'b0;
        second_write_enable_or_load <= 1'b1;
        write_n(2);
        check("offset_read", data_out, 17'h002);
        check("almost_empty_flag_n", almost_empty_flag_n, 1'h0);
        write_n(1);
        check("almost_empty_flag_n", almost_empty_flag_n, 1'h1);
        read_one(9'h000);
        $display("test load_mode done");
    endtask

    task automatic t_full();
        int n = 0;
        logic [16:0] af_at = 17'h0;
        do_reset(1'b1);
        @(posedge core_clk);
        wr_go <= 1'b1;
        while (full_flag_n !== 1'b0 && n < 70000) begin
            @(posedge core_clk);
            n++;
            if (almost_full_flag_n === 1'b0 && af_at == 0) af_at = wr_cnt;
        end
        check("wait_bound", n >= 70000, 17'h0);
        if (n >= 70000) results();
        check("almost_full_at", af_at, 17'h0fff9);
        check("full_at", wr_cnt, 17'h10000);
        rude <= 1'b1;
        repeat (4) @(posedge core_clk);
        check("full_flag_n", full_flag_n, 1'h0);
        rude <= 1'b0;
        wr_go <= 1'b0;
        read_one(9'h000);
        check("full_flag_n", full_flag_n, 1'h1);
        for (int i = 1; i < 8; i++) begin
            read_one(i[8:0]);
            if (i == 6) check("af", almost_full_flag_n, 1'h0);
        end
        check("almost_full_flag_n", almost_full_flag_n, 1'h1);
        $display("test full done");
    endtask

    initial begin
        do_reset(1'b1);
        t_reset_state();
        t_first_words();
        t_pin_gate();
        t_load_mode();
        t_full();
        results();
    end
endmodule
